// file: hw/tsac_top.sv
// module: tag side slotted anticollision state and reply logic
// Summary of operation
// - hold an 8-bit identifier, 256 possible tags
// - new random identifier at ready and inventory_start
// - identifier bits 3..0 form the slot index
// - slot_zero_poll redraws only the slot index
// - reply to slot_zero_poll when new index zero
// - slot_poll replies only when parameter equals index
// - a round has sixteen slots, zero first
// - inventory_start reply ignores the slot index
// - at most one reply per round
// - slot polls only honoured in inventory state
// - ready tag ignores polls until inventory_start
// - after anticollision only one tag transmits
// - tag never transmits without a command
// - ready plus inventory_start goes to inventory
// - selected tag ignores all anticollision commands
module tsac_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // decoded command from the frame receiver, one-cycle strobe
  input wire logic cmd_valid,
  input wire tsac_pkg::tsac_cmd_t cmd_code,
  input wire logic [tsac_pkg::SLOT_W-1:0] slot_parameter,
  input wire logic [tsac_pkg::ID_W-1:0] cmd_identifier,
  // reply to the frame transmitter
  output logic reply_valid,
  output logic [tsac_pkg::ID_W-1:0] reply_identifier,
  // status
  output logic [tsac_pkg::ID_W-1:0] tag_identifier,
  output logic [tsac_pkg::SLOT_W-1:0] slot_index,
  output logic in_inventory,
  output logic in_selected
);
  tsac_rng_if rng ();
  tsac_rng u_rng (
    .clk(clk),
    .rst(rst),
    .rng(rng)
  );

  tsac_pkg::tsac_state_t state_reg;
  tsac_pkg::tsac_state_t state_next;
  logic [tsac_pkg::ID_W-1:0] id_reg;
  logic [tsac_pkg::ID_W-1:0] id_next;
  logic loaded_reg;
  logic answered_reg;
  logic answered_next;
  logic reply_reg;
  logic reply_next;
  logic [tsac_pkg::ID_W-1:0] reply_id_reg;

  // command decode
  wire logic is_inv = state_reg == tsac_pkg::TSAC_INVENTORY;
  wire logic is_ready = state_reg == tsac_pkg::TSAC_READY;
  wire logic c_start = cmd_valid && cmd_code == tsac_pkg::TSAC_CMD_INVENTORY_START;
  wire logic c_pzero = cmd_valid && cmd_code == tsac_pkg::TSAC_CMD_SLOT_ZERO_POLL;
  wire logic c_poll = cmd_valid && cmd_code == tsac_pkg::TSAC_CMD_SLOT_POLL;
  wire logic c_sel = cmd_valid && cmd_code == tsac_pkg::TSAC_CMD_SELECT;
  wire logic c_comp = cmd_valid && cmd_code == tsac_pkg::TSAC_CMD_COMPLETION;
  wire logic c_rti = cmd_valid && cmd_code == tsac_pkg::TSAC_CMD_RESET_TO_INVENTORY;
  wire logic id_match = cmd_identifier == id_reg;
  // start honoured in ready and inventory only
  wire logic do_start = c_start && (is_ready || is_inv);
  wire logic do_pzero = c_pzero && is_inv;
  wire logic do_poll = c_poll && is_inv;
  wire logic [tsac_pkg::SLOT_W-1:0] new_slot = rng.value[tsac_pkg::SLOT_W-1:0];
  // slot zero poll reply uses freshly drawn index
  wire logic pzero_hit = do_pzero && new_slot == tsac_pkg::SLOT_ZERO;
  wire logic poll_hit = do_poll && slot_parameter == id_reg[tsac_pkg::SLOT_W-1:0];
  wire logic slot_reply = (pzero_hit || poll_hit) && !answered_reg;

  assign rng.step = do_start || do_pzero || !loaded_reg;

  always_comb begin
    state_next = state_reg;
    id_next = id_reg;
    answered_next = answered_reg;
    reply_next = 1'b0;
    if (!loaded_reg) begin
      id_next = rng.value;
    end
    case (state_reg)
      tsac_pkg::TSAC_READY: begin
        if (do_start) begin
          state_next = tsac_pkg::TSAC_INVENTORY;
        end
      end
      tsac_pkg::TSAC_INVENTORY: begin
        if (c_sel && id_match) begin
          state_next = tsac_pkg::TSAC_SELECTED;
        end
      end
      tsac_pkg::TSAC_SELECTED: begin
        if (c_sel && !id_match) begin
          state_next = tsac_pkg::TSAC_DESELECTED;
        end else if (c_comp) begin
          state_next = tsac_pkg::TSAC_DEACTIVATED;
        end else if (c_rti) begin
          state_next = tsac_pkg::TSAC_INVENTORY;
        end
      end
      tsac_pkg::TSAC_DESELECTED: begin
        if (c_sel && id_match) begin
          state_next = tsac_pkg::TSAC_SELECTED;
        end
      end
      tsac_pkg::TSAC_DEACTIVATED: begin
        state_next = tsac_pkg::TSAC_DEACTIVATED;
      end
      default: begin
        state_next = tsac_pkg::TSAC_READY;
      end
    endcase
    if (do_start) begin
      id_next = rng.value;
      answered_next = 1'b0;
      reply_next = 1'b1;
    end else if (do_pzero) begin
      id_next = {id_reg[tsac_pkg::ID_W-1:tsac_pkg::SLOT_W], new_slot};
      answered_next = answered_reg || pzero_hit;
      reply_next = slot_reply;
    end else if (do_poll) begin
      answered_next = answered_reg || poll_hit;
      reply_next = slot_reply;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= tsac_pkg::TSAC_READY;
      id_reg <= tsac_pkg::ID_RESET;
      loaded_reg <= 1'b0;
      answered_reg <= 1'b0;
      reply_reg <= 1'b0;
      reply_id_reg <= tsac_pkg::ID_RESET;
    end else begin
      state_reg <= state_next;
      id_reg <= id_next;
      loaded_reg <= 1'b1;
      answered_reg <= answered_next;
      reply_reg <= reply_next;
      reply_id_reg <= id_next;
    end
  end

  assign reply_valid = reply_reg;
  assign reply_identifier = reply_id_reg;
  assign tag_identifier = id_reg;
  assign slot_index = id_reg[tsac_pkg::SLOT_LSB+:tsac_pkg::SLOT_W];
  assign in_inventory = is_inv;
  assign in_selected = state_reg == tsac_pkg::TSAC_SELECTED;
endmodule

// file: hw/tsac_pkg.sv
// package: states, command codes, widths and reset values for the anticollision block
package tsac_pkg;
  localparam int unsigned ID_W = 8;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned SLOT_LSB = 0;
  localparam int unsigned SLOT_COUNT = 16;
  localparam logic [ID_W-1:0] ID_RESET = 8'h00;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  localparam logic [SLOT_W-1:0] SLOT_ZERO = 4'h0;
  typedef enum logic [2:0] {
    TSAC_CMD_NONE,
    TSAC_CMD_INVENTORY_START,
    TSAC_CMD_SLOT_ZERO_POLL,
    TSAC_CMD_SLOT_POLL,
    TSAC_CMD_SELECT,
    TSAC_CMD_COMPLETION,
    TSAC_CMD_RESET_TO_INVENTORY
  } tsac_cmd_t;
  typedef enum {
    TSAC_READY,
    TSAC_INVENTORY,
    TSAC_SELECTED,
    TSAC_DESELECTED,
    TSAC_DEACTIVATED
  } tsac_state_t;
endpackage

// file: hw/tsac_rng_if.sv
// interface: random source request and draw between top and generator
interface tsac_rng_if;
  logic step;
  logic [tsac_pkg::ID_W-1:0] value;
  modport src (input step, output value);
  modport user (output step, input value);
endinterface

// file: hw/tsac_rng.sv
// module: free-running lfsr random source for identifier draws
module tsac_rng (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // random draw port
  tsac_rng_if.src rng
);
  logic [15:0] lfsr_reg;
  logic [15:0] lfsr_next;
  logic [15:0] lfsr_skip;
  wire logic fb = lfsr_reg[0];
  wire logic fb_skip = lfsr_next[0];
  assign lfsr_next = fb ? ((lfsr_reg >> 1) ^ tsac_pkg::LFSR_TAPS) : (lfsr_reg >> 1);
  // double step advances the sequence two states on a draw
  assign lfsr_skip = fb_skip ? ((lfsr_next >> 1) ^ tsac_pkg::LFSR_TAPS) : (lfsr_next >> 1);
  assign rng.value = lfsr_reg[tsac_pkg::ID_W-1:0];
  // runs every cycle, extra step on each draw to decorrelate
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_reg <= tsac_pkg::LFSR_SEED;
    end else if (rng.step) begin
      lfsr_reg <= lfsr_skip;
    end else begin
      lfsr_reg <= lfsr_next;
    end
  end
endmodule

// file: tb/tsac_checker.sv
// checker: port-level assertions for the anticollision block
module tsac_checker (
  // clock and reset
  input logic clk,
  input logic rst,
  // command, reply and status
  input logic cmd_valid,
  input tsac_pkg::tsac_cmd_t cmd_code,
  input logic [3:0] slot_parameter,
  input logic reply_valid,
  input logic [7:0] reply_identifier,
  input logic [7:0] tag_identifier,
  input logic [3:0] slot_index,
  input logic in_inventory,
  input logic in_selected
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  wire zp = cmd_valid && cmd_code == tsac_pkg::TSAC_CMD_SLOT_ZERO_POLL;
  wire sp = cmd_valid && cmd_code == tsac_pkg::TSAC_CMD_SLOT_POLL;
  wire st = cmd_valid && cmd_code == tsac_pkg::TSAC_CMD_INVENTORY_START;
  chk_reply_cause: assert property (reply_valid |-> $past(cmd_valid))
    else $error("reply without command");
  chk_reply_word: assert property (reply_valid |-> reply_identifier == tag_identifier)
    else $error("reply word differs");
  chk_slot_bits: assert property (slot_index == tag_identifier[3:0])
    else $error("slot index not low nibble");
  chk_upper_kept: assert property (zp && in_inventory |=> $stable(tag_identifier[7:4]))
    else $error("upper bits changed");
  chk_zero_hit: assert property (reply_valid && $past(zp) |-> slot_index == 4'h0)
    else $error("slot zero reply on nonzero");
  chk_slot_hit: assert property (reply_valid && $past(sp) |-> slot_index == $past(slot_parameter))
    else $error("slot reply mismatch");
  chk_start_ans: assert property (st && in_inventory |=> reply_valid && in_inventory)
    else $error("start not answered");
  chk_poll_gate: assert property ((zp || sp) && !in_inventory |=> !reply_valid)
    else $error("poll answered outside inventory");
  chk_sel_quiet: assert property (in_selected && cmd_valid |=> !reply_valid)
    else $error("selected tag replied");
  cover property (reply_valid && $past(zp));
  cover property (reply_valid && $past(sp));
  cover property (st ##1 reply_valid);
endmodule

bind tsac_top tsac_checker chk_u (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .slot_parameter(slot_parameter), .reply_valid(reply_valid),
  .reply_identifier(reply_identifier), .tag_identifier(tag_identifier),
  .slot_index(slot_index), .in_inventory(in_inventory), .in_selected(in_selected));

// file: tb/tsac_reader.sv
// model: reader controller issuing commands and collecting replies
module tsac_reader (
  // clock
  input logic clk,
  // command out, reply in
  output tsac_pkg::tsac_cmd_t cmd_code,
  output logic cmd_valid,
  output logic [3:0] slot_parameter,
  output logic [7:0] cmd_identifier,
  input logic reply_valid,
  input logic [7:0] reply_identifier
);
  timeunit 1ns;
  timeprecision 1ps;
  logic got;
  logic [7:0] got_id;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = tsac_pkg::TSAC_CMD_NONE;
    slot_parameter = 4'h0;
    cmd_identifier = 8'h00;
  end
  task automatic send(input tsac_pkg::tsac_cmd_t c, input logic [3:0] p, input logic [7:0] i);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    slot_parameter = p;
    cmd_identifier = i;
    @(negedge clk);
    cmd_valid = 1'b0;
    slot_parameter = ~p;
    cmd_identifier = ~i;
    got = reply_valid;
    got_id = reply_identifier;
  endtask
  task automatic round(output int n, output logic [7:0] id);
    n = 0;
    send(tsac_pkg::TSAC_CMD_SLOT_ZERO_POLL, 4'h0, 8'h00);
    for (int s = 0; s < 16; s++) begin
      if (s > 0) send(tsac_pkg::TSAC_CMD_SLOT_POLL, 4'(s), 8'h00);
      if (got) begin
        n++;
        id = got_id;
      end
    end
  endtask
endmodule

// file: tb/tb_top.sv
// testbench: reader model against the tag anticollision block
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  int fails = 0;
  int checked = 0;
  wire cv, rv, inv, sel;
  wire tsac_pkg::tsac_cmd_t cc;
  wire [3:0] sp, si;
  wire [7:0] ci, rid, tid;
  always #5 clk = ~clk;
  tsac_reader rd_u (.clk(clk), .cmd_code(cc), .cmd_valid(cv), .slot_parameter(sp),
    .cmd_identifier(ci), .reply_valid(rv), .reply_identifier(rid));
  tsac_top dut_u (.clk(clk), .rst(rst), .cmd_valid(cv), .cmd_code(cc), .slot_parameter(sp),
    .cmd_identifier(ci), .reply_valid(rv), .reply_identifier(rid), .tag_identifier(tid),
    .slot_index(si), .in_inventory(inv), .in_selected(sel));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_ready_quiet;
    rd_u.send(tsac_pkg::TSAC_CMD_SLOT_ZERO_POLL, 4'h0, 8'h00);
    `CHK(rd_u.got, 1'b0)
    rd_u.send(tsac_pkg::TSAC_CMD_SLOT_POLL, si, 8'h00);
    `CHK(rd_u.got, 1'b0)
    `CHK(inv, 1'b0)
  endtask
  task automatic t_start;
    rd_u.send(tsac_pkg::TSAC_CMD_INVENTORY_START, 4'h0, 8'h00);
    `CHK(rd_u.got, 1'b1)
    `CHK(rd_u.got_id, tid)
    `CHK(inv, 1'b1)
  endtask
  task automatic t_rounds;
    int n;
    logic [7:0] id;
    logic [3:0] up;
    up = tid[7:4];
    rd_u.round(n, id);
    `CHK(n, 1)
    `CHK(tid[7:4], up)
    `CHK(id, tid)
    rd_u.round(n, id);
    `CHK(n, 0)
    rd_u.send(tsac_pkg::TSAC_CMD_INVENTORY_START, 4'h0, 8'h00);
    `CHK(rd_u.got, 1'b1)
    `CHK(rd_u.got_id, tid)
  endtask
  task automatic t_select;
    rd_u.send(tsac_pkg::TSAC_CMD_SELECT, 4'h0, tid);
    `CHK(sel, 1'b1)
    rd_u.send(tsac_pkg::TSAC_CMD_INVENTORY_START, 4'h0, 8'h00);
    `CHK(rd_u.got, 1'b0)
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_ready_quiet();
    t_start();
    t_rounds();
    t_select();
    close_out();
  end
endmodule
